// >>> verilog/fcx_frame_crc.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module fcx_fifo
  import fcx_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 16,
  localparam int AW = $clog2(D),
  localparam int CW = $clog2(D + 1)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [CW-1:0] count
);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic rdy_ff, nxt_rdy;
  logic push, pop;

  always_comb begin
    push = in_valid && rdy_ff;
    pop = out_ready && (cnt_ff != '0);
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (push) begin
      nxt_wp = (wp_ff == AW'(D - 1)) ? '0 : AW'(wp_ff + 1'b1);
    end
    if (pop) begin
      nxt_rp = (rp_ff == AW'(D - 1)) ? '0 : AW'(rp_ff + 1'b1);
    end
    nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
    nxt_rdy = nxt_cnt != CW'(D);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else if (ce) begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  assign in_ready = rdy_ff;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rp_ff];
  assign count = cnt_ff;
endmodule

module fcx_frame_crc
  import fcx_pkg::*;
#(
  parameter int ETU_CYC = FCX_ETU_CYC,
  parameter int FIFO_D = 16,
  localparam int EW = $clog2(ETU_CYC + 1),
  localparam int CW = $clog2(FIFO_D + 1)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic miller_sel,
  input wire logic pulse_position_sel,
  input wire logic [15:0] user_preset,
  output logic tx_mod,
  output logic tx_active,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_end,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_crc_err
);
  logic [1:0] rs_ff;
  logic rst_s;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs_ff <= 2'h0;
    end else begin
      rs_ff <= {rs_ff[0], 1'b1};
    end
  end
  assign rst_s = rs_ff[1];

  // Register file
  logic [7:0] txc_ff, nxt_txc, rxc_ff, nxt_rxc, num_ff, nxt_num, pw_ff, nxt_pw;
  logic [7:0] rd_ff, nxt_rd;
  logic pend_ff, nxt_pend, err_ff, nxt_err;
  logic go, set_err, f_valid, f_pop;
  logic [7:0] f_data;
  logic [CW-1:0] f_cnt;
  fcx_tx_st_t st_ff, nxt_st;
  fcx_crc_cfg_t txcfg, rxcfg;

  assign txcfg = fcx_crc_cfg_t'(txc_ff[6:0]);
  assign rxcfg = fcx_crc_cfg_t'(rxc_ff[6:0]);

  always_comb begin
    nxt_txc = txc_ff;
    nxt_rxc = rxc_ff;
    nxt_num = num_ff;
    nxt_pw = pw_ff;
    nxt_rd = 8'h00;
    nxt_pend = pend_ff && !go;
    nxt_err = err_ff || set_err;
    if (wr_en) begin
      case (addr)
        FCX_A_TX_CRC: nxt_txc = wr_data & FCX_TXC_MASK;
        FCX_A_RX_CRC: nxt_rxc = wr_data;
        FCX_A_TX_NUM: nxt_num = wr_data & FCX_NUM_MASK;
        FCX_A_TX_PW: nxt_pw = wr_data;
        FCX_A_CMD: nxt_pend = nxt_pend || wr_data[FCX_B_START];
        // Write one clears; a new mismatch in the same cycle wins
        FCX_A_STAT: nxt_err = (err_ff && !wr_data[FCX_B_ERR]) || set_err;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        FCX_A_TX_CRC: nxt_rd = txc_ff;
        FCX_A_RX_CRC: nxt_rd = rxc_ff;
        FCX_A_TX_NUM: nxt_rd = num_ff;
        FCX_A_TX_PW: nxt_rd = pw_ff;
        FCX_A_STAT: nxt_rd = {4'h0, f_cnt == '0, !tx_ready, st_ff != FCX_IDLE, err_ff};
        default: nxt_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_s) begin
    if (!rst_s) begin
      txc_ff <= FCX_REG_RST;
      rxc_ff <= FCX_REG_RST;
      num_ff <= FCX_REG_RST;
      pw_ff <= FCX_REG_RST;
      rd_ff <= FCX_REG_RST;
      pend_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (ce) begin
      txc_ff <= nxt_txc;
      rxc_ff <= nxt_rxc;
      num_ff <= nxt_num;
      pw_ff <= nxt_pw;
      rd_ff <= nxt_rd;
      pend_ff <= nxt_pend;
      err_ff <= nxt_err;
    end
  end
  assign rd_data = rd_ff;
  assign rx_crc_err = err_ff;

  fcx_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clock(clock),
    .rst_n(rst_s),
    .ce(ce),
    .in_valid(tx_valid),
    .in_data(tx_byte),
    .in_ready(tx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop),
    .count(f_cnt)
  );

  // Transmit bit engine
  logic [EW-1:0] etu_ff, nxt_etu, off;
  logic [4:0] idx_ff, nxt_idx, nb_ff, nxt_nb;
  logic [15:0] sh_ff, nxt_sh, crc_ff, nxt_crc, crc_now, crc_out;
  logic bit_ff, nxt_bit, last_ff, nxt_last, mod_ff, nxt_mod, act_ff;
  logic etu_end, grid, data_en, pulse_on, last_ld;
  logic [2:0] lbits;

  assign etu_end = etu_ff == EW'(ETU_CYC - 1);
  assign grid = num_ff[FCX_B_GRID];
  assign data_en = num_ff[FCX_B_DATA];
  assign lbits = num_ff[FCX_B_LAST +: 3];
  assign go = (st_ff == FCX_IDLE) && pend_ff && (!grid || etu_end);
  assign off = pulse_position_sel ? EW'(ETU_CYC / 2) : '0;
  // Pulse spans width+1 clocks; bit counter wrap cuts it at bit end
  assign pulse_on = (etu_ff >= off) &&
                    ({8'h00, etu_ff} <= {8'h00, off} + (EW + 8)'(pw_ff));
  assign last_ld = f_cnt == CW'(1);

  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_nb = nb_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_last = last_ff;
    nxt_crc = crc_ff;
    f_pop = 1'b0;
    nxt_etu = etu_end ? '0 : EW'(etu_ff + 1'b1);
    crc_now = (st_ff == FCX_DATA) ? fcx_step(crc_ff, bit_ff, txcfg.kind) : crc_ff;
    crc_out = txcfg.inv ? (~crc_now & fcx_mask(txcfg.kind)) : crc_now;
    if (go) begin
      if (!grid) begin
        nxt_etu = '0;
      end
      nxt_st = FCX_SYM;
      nxt_bit = 1'b1;
      nxt_idx = '0;
      nxt_nb = 5'h01;
      nxt_crc = fcx_preset(txcfg.kind, txcfg.init, user_preset);
    end else if (st_ff != FCX_IDLE && etu_end) begin
      nxt_crc = crc_now;
      if (idx_ff + 5'h01 < nb_ff) begin
        nxt_idx = idx_ff + 5'h01;
        nxt_sh = sh_ff >> 1;
        nxt_bit = sh_ff[1];
      end else if (data_en && f_valid && (st_ff == FCX_SYM || !last_ff)) begin
        f_pop = 1'b1;
        nxt_st = FCX_DATA;
        nxt_sh = {8'h00, f_data};
        nxt_bit = f_data[0];
        nxt_idx = '0;
        nxt_last = last_ld;
        nxt_nb = (last_ld && lbits != 3'h0) ? {2'h0, lbits} : {1'b0, FCX_BYTE_BITS};
      end else if (data_en && txcfg.en && st_ff != FCX_CRC) begin
        nxt_st = FCX_CRC;
        nxt_sh = crc_out;
        nxt_bit = crc_out[0];
        nxt_idx = '0;
        nxt_nb = fcx_width(txcfg.kind);
      end else begin
        nxt_st = FCX_IDLE;
      end
    end
    // Miller: pulse on ones and on symbols; otherwise plain level
    nxt_mod = (st_ff != FCX_IDLE) && bit_ff && (!miller_sel || pulse_on);
  end

  always_ff @(posedge clock or negedge rst_s) begin
    if (!rst_s) begin
      st_ff <= FCX_IDLE;
      etu_ff <= '0;
      idx_ff <= '0;
      nb_ff <= '0;
      sh_ff <= '0;
      bit_ff <= 1'b0;
      last_ff <= 1'b0;
      crc_ff <= '0;
      mod_ff <= 1'b0;
      act_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      etu_ff <= nxt_etu;
      idx_ff <= nxt_idx;
      nb_ff <= nxt_nb;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      last_ff <= nxt_last;
      crc_ff <= nxt_crc;
      mod_ff <= nxt_mod;
      act_ff <= nxt_st != FCX_IDLE;
    end
  end
  assign tx_mod = mod_ff;
  assign tx_active = act_ff;

  // Receive checker: last CRC-width bits are held back from the CRC
  logic [15:0] dl_ff, nxt_dl, rcrc_ff, nxt_rcrc, tail, expect_crc;
  logic [4:0] rcnt_ff, nxt_rcnt, rw;
  logic [3:0] acnt_ff, nxt_acnt;
  logic [7:0] asm_ff, nxt_asm, rxb_ff, nxt_rxb;
  logic rxv_ff, nxt_rxv, drop_ok, drop, src_v, src_b, store;

  always_comb begin
    rw = fcx_width(rxcfg.kind);
    store = rxc_ff[FCX_B_STORE];
    drop_ok = rcnt_ff >= rw;
    drop = dl_ff[4'(rw - 5'h01)];
    for (int i = 0; i < 16; i++) begin
      tail[i] = (5'(i) < rw) ? dl_ff[4'(rw - 5'(i) - 5'h01)] : 1'b0;
    end
    expect_crc = rxcfg.inv ? (~rcrc_ff & fcx_mask(rxcfg.kind)) : rcrc_ff;
    nxt_dl = dl_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rcrc = rcrc_ff;
    nxt_asm = asm_ff;
    nxt_acnt = acnt_ff;
    nxt_rxb = rxb_ff;
    nxt_rxv = 1'b0;
    set_err = 1'b0;
    src_v = rx_bit_valid && (store || drop_ok);
    src_b = store ? rx_bit : drop;
    if (!drop_ok) begin
      nxt_rcrc = fcx_preset(rxcfg.kind, rxcfg.init, user_preset);
    end
    if (rx_bit_valid) begin
      nxt_dl = {dl_ff[14:0], rx_bit};
      nxt_rcnt = (rcnt_ff == 5'h1f) ? rcnt_ff : rcnt_ff + 5'h01;
      if (drop_ok) begin
        nxt_rcrc = fcx_step(rcrc_ff, drop, rxcfg.kind);
      end
    end
    if (src_v) begin
      nxt_asm = {src_b, asm_ff[7:1]};
      nxt_acnt = acnt_ff + 4'h1;
      if (acnt_ff == FCX_BYTE_BITS - 4'h1) begin
        nxt_rxb = {src_b, asm_ff[7:1]};
        nxt_rxv = 1'b1;
        nxt_acnt = 4'h0;
      end
    end
    if (rx_end) begin
      set_err = rxcfg.en && (!drop_ok || tail != expect_crc);
      if (acnt_ff != 4'h0) begin
        nxt_rxb = asm_ff >> (FCX_BYTE_BITS - acnt_ff);
        nxt_rxv = 1'b1;
      end
      nxt_dl = '0;
      nxt_rcnt = '0;
      nxt_acnt = 4'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_s) begin
    if (!rst_s) begin
      dl_ff <= '0;
      rcnt_ff <= '0;
      rcrc_ff <= '0;
      asm_ff <= '0;
      acnt_ff <= '0;
      rxb_ff <= '0;
      rxv_ff <= 1'b0;
    end else if (ce) begin
      dl_ff <= nxt_dl;
      rcnt_ff <= nxt_rcnt;
      rcrc_ff <= nxt_rcrc;
      asm_ff <= nxt_asm;
      acnt_ff <= nxt_acnt;
      rxb_ff <= nxt_rxb;
      rxv_ff <= nxt_rxv;
    end
  end
  assign rx_byte = rxb_ff;
  assign rx_byte_valid = rxv_ff;

  crc_kind_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && $rose(st_ff == FCX_CRC) |-> nb_ff == fcx_width(txcfg.kind))
    else $error("CRC length does not match kind");
  tx_preset_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && go |=> crc_ff == fcx_preset($past(txcfg.kind), $past(txcfg.init), $past(user_preset)))
    else $error("Transmit CRC preset wrong");
  rx_preset_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && rx_bit_valid && rcnt_ff == 5'h00 |=> rcrc_ff == fcx_preset($past(rxcfg.kind),
      $past(rxcfg.init), $past(user_preset)))
    else $error("Receive CRC preset wrong");
  crc_append_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && st_ff == FCX_DATA && etu_end && idx_ff + 5'h01 >= nb_ff && last_ff && txcfg.en
    |=> st_ff == FCX_CRC && bit_ff == $past(crc_out[0]))
    else $error("CRC not appended");
  rx_check_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && !rxcfg.en && !(wr_en && addr == FCX_A_STAT) |=> err_ff == $past(err_ff))
    else $error("Error flag changed while check off");
  grid_start_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && go && grid |=> etu_ff == '0 && st_ff == FCX_SYM)
    else $error("Start off the bit grid");
  sym_only_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && st_ff == FCX_SYM && etu_end && !data_en |=> st_ff == FCX_IDLE)
    else $error("Data sent with data enable clear");
  last_bits_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && f_pop && last_ld && lbits != 3'h0 |=> nb_ff == {2'h0, $past(lbits)})
    else $error("Final byte bit count wrong");
  pulse_end_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && miller_sel && ({8'h00, etu_ff} > {8'h00, off} + (EW + 8)'(pw_ff) || etu_ff < off)
    |=> !tx_mod)
    else $error("Modulation pulse too long");
  sym_pulse_a: assert property (@(posedge clock) disable iff (!rst_s)
    ce && miller_sel && st_ff == FCX_SYM && etu_ff == off |=> tx_mod)
    else $error("Symbol pulse missing");
endmodule

// >>> verilog/fcx_pkg.sv
// Function
// - Kind code selects CRC5, CRC8 or CRC16
// - Transmit preset codes 1 to 3 load table, 0 loads zero
// - Code 7 all ones, 6 user, 4/5 none
// - Receive preset uses the same code table
// - Transmit enable appends computed CRC to frame
// - Transmit invert complements CRC before sending
// - Receive enable checks CRC, flags mismatch error
// - Receive invert compares against complemented CRC
// - Store enable copies received CRC bytes out
// - Grid bit starts transmissions on ETU boundaries
// - Data enable clear sends single symbol only
// - Last-bits field trims final byte, zero whole
// - Miller pulse lasts width plus one clocks
// - Pulse never runs past bit end
// - Width applies in Miller mode, symbols too
package fcx_pkg;
  localparam logic [7:0] FCX_A_TX_CRC = 8'h2c;
  localparam logic [7:0] FCX_A_RX_CRC = 8'h2d;
  localparam logic [7:0] FCX_A_TX_NUM = 8'h2e;
  localparam logic [7:0] FCX_A_TX_PW = 8'h2f;
  localparam logic [7:0] FCX_A_STAT = 8'h40;
  localparam logic [7:0] FCX_A_CMD = 8'h41;
  localparam logic [7:0] FCX_REG_RST = 8'h00;
  localparam logic [7:0] FCX_TXC_MASK = 8'h7f;
  localparam logic [7:0] FCX_NUM_MASK = 8'h1f;
  localparam int FCX_B_STORE = 7;
  localparam int FCX_B_LAST = 0;
  localparam int FCX_B_DATA = 3;
  localparam int FCX_B_GRID = 4;
  localparam int FCX_B_START = 0;
  localparam int FCX_B_ERR = 0;
  localparam int FCX_ETU_NS = 9440;
  localparam int FCX_CLK_NS = 50;
  localparam int FCX_ETU_CYC = FCX_ETU_NS / FCX_CLK_NS;
  localparam logic [3:0] FCX_BYTE_BITS = 4'h8;
  localparam logic [4:0] FCX_W16 = 5'h10;
  localparam logic [4:0] FCX_W8 = 5'h08;
  localparam logic [4:0] FCX_W5 = 5'h05;
  localparam logic [15:0] FCX_POLY16 = 16'h8408;
  localparam logic [15:0] FCX_POLY8 = 16'h00b8;
  localparam logic [15:0] FCX_POLY5 = 16'h0012;
  localparam logic [15:0] FCX_P16_A = 16'h6363;
  localparam logic [15:0] FCX_P16_B = 16'ha671;
  localparam logic [15:0] FCX_P16_C = 16'hfffe;
  localparam logic [15:0] FCX_P8_A = 16'h0012;
  localparam logic [15:0] FCX_P8_B = 16'h00bf;
  localparam logic [15:0] FCX_P8_C = 16'h00fd;
  localparam logic [2:0] FCX_PRE_ZERO = 3'h0;
  localparam logic [2:0] FCX_PRE_A = 3'h1;
  localparam logic [2:0] FCX_PRE_B = 3'h2;
  localparam logic [2:0] FCX_PRE_C = 3'h3;
  localparam logic [2:0] FCX_PRE_USER = 3'h6;
  localparam logic [2:0] FCX_PRE_ONES = 3'h7;
  typedef enum logic [1:0] {
    FCX_CRC5 = 2'h0, FCX_CRC8 = 2'h1, FCX_CRC16 = 2'h2
  } fcx_kind_t;
  typedef enum logic [1:0] {FCX_IDLE, FCX_SYM, FCX_DATA, FCX_CRC} fcx_tx_st_t;
  typedef struct packed {
    logic [2:0] init;
    logic [1:0] kind;
    logic inv;
    logic en;
  } fcx_crc_cfg_t;

  function automatic logic [15:0] fcx_mask(input logic [1:0] kind);
    case (kind)
      FCX_CRC16: return 16'hffff;
      FCX_CRC8: return 16'h00ff;
      default: return 16'h001f;
    endcase
  endfunction

  function automatic logic [4:0] fcx_width(input logic [1:0] kind);
    case (kind)
      FCX_CRC16: return FCX_W16;
      FCX_CRC8: return FCX_W8;
      default: return FCX_W5;
    endcase
  endfunction

  // One LSB-first CRC shift step
  function automatic logic [15:0] fcx_step(input logic [15:0] crc, input logic b,
                                           input logic [1:0] kind);
    logic [15:0] poly;
    poly = (kind == FCX_CRC16) ? FCX_POLY16 : (kind == FCX_CRC8) ? FCX_POLY8 : FCX_POLY5;
    return ((crc >> 1) ^ ((crc[0] ^ b) ? poly : 16'h0000)) & fcx_mask(kind);
  endfunction

  function automatic logic [15:0] fcx_preset(input logic [1:0] kind, input logic [2:0] sel,
                                             input logic [15:0] user);
    logic w16;
    logic w8;
    w16 = kind == FCX_CRC16;
    w8 = kind == FCX_CRC8;
    case (sel)
      FCX_PRE_A: return w16 ? FCX_P16_A : FCX_P8_A;
      FCX_PRE_B: return w16 ? FCX_P16_B : w8 ? FCX_P8_B : 16'h0000;
      FCX_PRE_C: return w16 ? FCX_P16_C : w8 ? FCX_P8_C : 16'h0000;
      FCX_PRE_USER: return user & fcx_mask(kind);
      FCX_PRE_ONES: return fcx_mask(kind);
      default: return 16'h0000;
    endcase
  endfunction
endpackage

// >>> verif/fcx_card_model.sv
`timescale 1ns/100ps
module fcx_card_model
  import fcx_pkg::*;
#(
  parameter int ETU = 8
) (
  input wire logic clock,
  input wire logic tx_mod,
  input wire logic tx_active,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic rx_end
);
  logic got[$];
  int pos;
  initial begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_end = 1'b0;
    pos = 0;
  end
  // Mid-bit sample of the level envelope
  always @(negedge clock) begin
    if (tx_active !== 1'b1) begin
      pos = 0;
    end else begin
      if (pos % ETU == ETU / 2) begin
        got.push_back(tx_mod);
      end
      pos++;
    end
  end
  // Reply LSB first; data line shows the inverse between bits
  task automatic send(input logic [39:0] v, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_bit <= v[i];
      rx_bit_valid <= 1'b1;
      @(posedge clock);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~v[i];
      repeat (gap) @(posedge clock);
    end
    @(posedge clock);
    rx_end <= 1'b1;
    @(posedge clock);
    rx_end <= 1'b0;
  endtask
endmodule

// >>> verif/frame_crc_and_tx_data_config_test.sv
`timescale 1ns/100ps
module frame_crc_and_tx_data_config_test
  import fcx_pkg::*;
;
  localparam int ETU = 8;
  typedef struct packed {
    logic [1:0] kind; logic [2:0] sel; logic inv; logic app; logic [2:0] last;
  } fcx_txrow_t;
  typedef struct packed {
    logic [1:0] kind; logic [2:0] sel; logic inv; logic en; logic st; logic bad; logic err;
    logic [2:0] nb;
  } fcx_rxrow_t;
  logic clock, rst_n, ce, wr_en, rd_en, tx_valid, tx_ready, miller_sel, pulse_position_sel;
  logic tx_mod, tx_active, rx_bit, rx_bit_valid, rx_end, rx_byte_valid, rx_crc_err, act_q;
  logic [7:0] addr, wr_data, rd_data, tx_byte, rx_byte, d, lb;
  logic [15:0] user_preset, crc, c;
  logic [1:0] ck;
  logic [39:0] v;
  logic expq[$];
  logic [7:0] rxq[$];
  int errors, n_checks, run, last_run, cyc, last_rise, rise_gap;
  fcx_txrow_t tr;
  fcx_rxrow_t xr;
  logic [7:0] rg[6][3] = '{'{8'h2c, 8'hff, 8'h7f}, '{8'h2d, 8'hff, 8'hff},
    '{8'h2e, 8'hff, 8'h1f}, '{8'h2f, 8'ha5, 8'ha5}, '{8'h30, 8'hff, 8'h00},
    '{8'h2c, 8'h00, 8'h00}};
  fcx_txrow_t txr[10] = '{
    '{2'h2, 3'h1, 1'h0, 1'h1, 3'h0},
    '{2'h1, 3'h7, 1'h1, 1'h1, 3'h0},
    '{2'h0, 3'h7, 1'h0, 1'h1, 3'h3},
    '{2'h2, 3'h6, 1'h0, 1'h1, 3'h6},
    '{2'h1, 3'h2, 1'h0, 1'h1, 3'h0},
    '{2'h2, 3'h3, 1'h1, 1'h1, 3'h0},
    '{2'h2, 3'h4, 1'h0, 1'h1, 3'h0},
    '{2'h1, 3'h3, 1'h0, 1'h0, 3'h0},
    '{2'h0, 3'h2, 1'h0, 1'h1, 3'h0},
    '{2'h3, 3'h7, 1'h0, 1'h1, 3'h0}};
  fcx_rxrow_t rxr[6] = '{
    '{2'h2, 3'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h2},
    '{2'h2, 3'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 3'h2},
    '{2'h2, 3'h7, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 3'h4},
    '{2'h1, 3'h2, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h2},
    '{2'h0, 3'h3, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 3'h2},
    '{2'h2, 3'h6, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 3'h2}};
  logic [13:0] pw[5] = '{{1'h1, 1'h0, 8'h02, 4'h3}, {1'h1, 1'h0, 8'hff, 4'h8},
    {1'h1, 1'h1, 8'hff, 4'h4}, {1'h1, 1'h1, 8'h01, 4'h2}, {1'h0, 1'h0, 8'h02, 4'h8}};

  fcx_frame_crc #(.ETU_CYC(ETU), .FIFO_D(16)) u_fcx_frame_crc (.clock(clock), .rst_n(rst_n),
    .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .miller_sel(miller_sel),
    .pulse_position_sel(pulse_position_sel), .user_preset(user_preset), .tx_mod(tx_mod),
    .tx_active(tx_active), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end),
    .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_crc_err(rx_crc_err));
  fcx_card_model #(.ETU(ETU)) u_fcx_card_model (.clock(clock), .tx_mod(tx_mod),
    .tx_active(tx_active), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end));

  always #25 clock = ~clock;
  always @(negedge clock) begin
    if (rx_byte_valid === 1'b1) rxq.push_back(rx_byte);
    run = (tx_mod === 1'b1) ? run + 1 : 0;
    if (run > 0) last_run = run;
    if (tx_active === 1'b1 && act_q !== 1'b1) begin
      rise_gap = cyc - last_rise;
      last_rise = cyc;
    end
    act_q = tx_active;
    cyc++;
  end

  function automatic logic [15:0] wmask(input logic [1:0] k);
    return (k == 2'h2) ? 16'hffff : (k == 2'h1) ? 16'h00ff : 16'h001f;
  endfunction
  function automatic int wid(input logic [1:0] k);
    return (k == 2'h2) ? 16 : (k == 2'h1) ? 8 : 5;
  endfunction
  function automatic logic [15:0] pre(input logic [1:0] k, input logic [2:0] s);
    case (s)
      3'h1: return (k == 2'h2) ? 16'h6363 : 16'h0012;
      3'h2: return (k == 2'h2) ? 16'ha671 : (k == 2'h1) ? 16'h00bf : 16'h0000;
      3'h3: return (k == 2'h2) ? 16'hfffe : (k == 2'h1) ? 16'h00fd : 16'h0000;
      3'h6: return user_preset & wmask(k);
      3'h7: return wmask(k);
      default: return 16'h0000;
    endcase
  endfunction
  // Expected bit stream, optionally folded into the running CRC
  task automatic addb(input logic [15:0] b, input int n, input logic upd);
    logic [15:0] p;
    p = (ck == 2'h2) ? FCX_POLY16 : (ck == 2'h1) ? FCX_POLY8 : FCX_POLY5;
    for (int i = 0; i < n; i++) begin
      expq.push_back(b[i]);
      if (upd) crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? p : 16'h0000);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    @(posedge clock);
    addr <= a;
    wr_data <= b;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    b = rd_data;
    @(posedge clock);
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge clock);
    tx_byte <= b;
    tx_valid <= 1'b1;
    @(negedge clock);
    while (tx_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask
  task automatic tx_frame();
    int k;
    k = 0;
    u_fcx_card_model.got.delete();
    wr(FCX_A_CMD, 8'h01);
    while (tx_active !== 1'b1 && k < 4 * ETU) begin @(negedge clock); k++; end
    while (tx_active === 1'b1 && k < 3000) begin @(negedge clock); k++; end
    chk(k < 3000, 1);
    @(posedge clock);
  endtask
  task automatic cmpq();
    chk(u_fcx_card_model.got.size(), expq.size());
    foreach (expq[j]) if (j < u_fcx_card_model.got.size()) chk(u_fcx_card_model.got[j], expq[j]);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    errors++;
    test_done();
  end
  initial begin
    {clock, rst_n, wr_en, rd_en, tx_valid, miller_sel, pulse_position_sel} = '0;
    {addr, wr_data, tx_byte, errors, n_checks, run, last_run, cyc, last_rise} = '0;
    ce = 1'b1;
    user_preset = 16'h5a3c;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk({tx_ready, rx_crc_err, tx_active}, 3'b100);
    foreach (rg[i]) begin rd(rg[i][0], d); chk(d, 8'h00); end
    foreach (rg[i]) begin
      wr(rg[i][0], rg[i][1]);
      rd(rg[i][0], d);
      chk(d, rg[i][2]);
    end
    foreach (txr[i]) begin
      tr = txr[i];
      push(8'h3c);
      push(8'hb2);
      wr(FCX_A_TX_CRC, {1'b0, tr.sel, tr.kind, tr.inv, tr.app});
      wr(FCX_A_TX_NUM, {5'h01, tr.last});
      expq.delete();
      ck = tr.kind;
      crc = pre(tr.kind, tr.sel);
      addb(16'h0001, 1, 1'b0);
      addb(16'h003c, 8, 1'b1);
      addb(16'h00b2, (tr.last == 3'h0) ? 8 : int'(tr.last), 1'b1);
      if (tr.app) addb(tr.inv ? ~crc : crc, wid(tr.kind), 1'b0);
      tx_frame();
      cmpq();
    end
    // FIFO filled to refusal, then drained by one long frame
    for (int i = 0; i < 16; i++) push(8'(i * 37));
    @(negedge clock);
    chk(tx_ready, 1'b0);
    rd(FCX_A_STAT, d);
    chk(d, 8'h04);
    wr(FCX_A_TX_CRC, 8'h00);
    wr(FCX_A_TX_NUM, 8'h08);
    expq.delete();
    addb(16'h0001, 1, 1'b0);
    for (int i = 0; i < 16; i++) addb(16'(8'(i * 37)), 8, 1'b0);
    tx_frame();
    cmpq();
    rd(FCX_A_STAT, d);
    chk(d, 8'h08);
    wr(FCX_A_TX_NUM, 8'h10);
    expq.delete();
    addb(16'h0001, 1, 1'b0);
    tx_frame();
    cmpq();
    repeat (3) @(posedge clock);
    tx_frame();
    chk(rise_gap % ETU, 0);
    wr(FCX_A_TX_NUM, 8'h00);
    foreach (pw[i]) begin
      miller_sel <= pw[i][13];
      pulse_position_sel <= pw[i][12];
      wr(FCX_A_TX_PW, pw[i][11:4]);
      last_run = 0;
      tx_frame();
      chk(last_run, {28'h0, pw[i][3:0]});
    end
    foreach (rxr[i]) begin
      xr = rxr[i];
      wr(FCX_A_STAT, 8'h01);
      wr(FCX_A_RX_CRC, {xr.st, xr.sel, xr.kind, xr.inv, xr.en});
      expq.delete();
      ck = xr.kind;
      crc = pre(xr.kind, xr.sel);
      addb(16'h003c, 8, 1'b1);
      if (xr.kind != 2'h0) addb(16'h00b2, 8, 1'b1);
      c = (xr.inv ? ~crc : crc) ^ {15'h0, xr.bad};
      addb(c, wid(xr.kind), 1'b0);
      foreach (expq[j]) v[j] = expq[j];
      rxq.delete();
      u_fcx_card_model.send(v, expq.size(), i % 3 + 1);
      repeat (3) @(posedge clock);
      chk(rx_crc_err, xr.err);
      rd(FCX_A_STAT, d);
      chk(d[FCX_B_ERR], xr.err);
      chk(rxq.size(), xr.nb);
      lb = (xr.kind == 2'h2) ? c[15:8] : (xr.kind == 2'h1) ? c[7:0] : {3'h0, c[4:0]};
      if (xr.st && rxq.size() > 0) chk(rxq[rxq.size() - 1], lb);
    end
    // Write while frozen must not land
    ce <= 1'b0;
    wr(FCX_A_TX_PW, 8'h33);
    ce <= 1'b1;
    rd(FCX_A_TX_PW, d);
    chk(d, 8'h02);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(FCX_A_TX_PW, d);
    chk(d, 8'h00);
    test_done();
  end
endmodule
